// *** csg_pkg.sv ***
// Purpose: Shared constants and types of the codec startup and clock gating
// Assumes: 40 MHz system clock, byte-wide decoded control-port requests
// Notes: Multi-byte registers are stored most significant byte first
package csg_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // Control-port map
  localparam logic [15:0] ADDR_CLK_CTRL = 16'h4000;
  localparam logic [15:0] ADDR_PLL_FIRST = 16'h4002;
  localparam logic [15:0] ADDR_PLL_LAST = 16'h4007;
  localparam logic [15:0] ADDR_DPD0 = 16'h4080;
  localparam logic [15:0] ADDR_DPD1 = 16'h4081;
  localparam logic [15:0] ADDR_RAM_FIRST = 16'h0000;
  localparam logic [15:0] ADDR_RAM_LAST = 16'h000F;

  // Internal memory geometry
  localparam int RAM_DEPTH = 16;
  localparam int RAM_AW = 4;
  localparam logic [RAM_AW-1:0] RAM_LAST_IDX = 4'hF;

  // Clock control fields
  localparam int CC_CORE_EN = 0;
  localparam int CC_DIV_LSB = 1;
  localparam int CC_SRC = 3;
  localparam logic [7:0] CC_RESET = 8'h00;

  // PLL control fields (bit positions in the 48-bit word)
  localparam int PLL_BYTES = 6;
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_LOCK_BIT = 1;
  localparam logic [47:0] PLL_RESET = 48'h0000_0000_0000;
  localparam logic [5:0] PLL_MASK_FULL = 6'h3F;

  // Digital power-down fields
  localparam int DPD0_DSP_BIT = 0;
  localparam int DPD0_ADC_BIT = 1;
  localparam int DPD0_DAC_BIT = 2;
  localparam int DPD0_MEMC_BIT = 6;
  localparam logic [7:0] DPD_RESET = 8'h00;

  // Timing
  localparam int LOCK_TIME_NS = 2_960_000;
  localparam int LOCK_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int POR_TIME_NS = 400;
  localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_BOOT = 2'b01,
    ST_RUN = 2'b10
  } csg_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic last;
    logic [15:0] addr;
    logic [7:0] wdata;
  } csg_cp_req_t;

endpackage

// *** csg_ram.sv ***
// Purpose: Small internal memory cleared by the boot sequence
// Assumes: One access per cycle, a read in a write cycle returns the old data
// Notes: Read data come out of a register one edge after the address
`timescale 1ns/100ps
`default_nettype none
module csg_ram (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [csg_pkg::RAM_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  import csg_pkg::*;

  logic [7:0] mem_r [RAM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_r[addr_i];
    end
  end
endmodule // csg_ram
`default_nettype wire

// *** csg_top.sv ***
// Purpose: Power-on reset, self-boot, access gating and core clock control
// Assumes: Control-port bytes arrive already decoded as csg_cp_req_t
// Notes: PLL lock is modelled by a timer started when the PLL is enabled
`timescale 1ns/100ps
`default_nettype none
module csg_top #(
  parameter int LOCK_CYCLES = csg_pkg::LOCK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hw_power_down_pin_i,
  input wire logic regulator_output_pin_i,
  input wire logic adc_osr_low_i,
  input wire logic dac_osr_low_i,
  input wire csg_pkg::csg_cp_req_t cp_req_i,
  output logic [7:0] cp_rdata_o,
  output logic cp_rvalid_o,
  output logic boot_done_o,
  output logic regulator_en_o,
  output logic core_clk_gate_o,
  output logic core_clk_src_o,
  output logic [1:0] core_clk_div_o,
  output logic pll_power_o,
  output logic [15:0] subsys_en_o,
  output logic adc_osr_128_o,
  output logic dac_osr_128_o
);
  import csg_pkg::*;

  function automatic logic is_clk_pll(input logic [15:0] a);
    return (a == ADDR_CLK_CTRL) ||
           ((a >= ADDR_PLL_FIRST) && (a <= ADDR_PLL_LAST));
  endfunction

  function automatic logic is_ram(input logic [15:0] a);
    return (a >= ADDR_RAM_FIRST) && (a <= ADDR_RAM_LAST);
  endfunction

  logic pdn_meta_r, pdn_s_r, reg_meta_r, reg_s_r;
  csg_state_t state_r;
  logic [7:0] por_cnt_r;
  logic [RAM_AW-1:0] boot_addr_r;
  logic [7:0] clk_ctrl_r, dpd0_r, dpd1_r;
  logic [47:0] pll_ctrl_r, pll_shadow_r;
  logic [5:0] pll_mask_r;
  logic [31:0] lock_cnt_r;
  logic locked_r;
  logic rd_pend_r, rd_ram_r;
  logic [15:0] rd_addr_r;

  // Pins are asynchronous to clk_i
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pdn_meta_r <= 1'b1;
      pdn_s_r <= 1'b1;
      reg_meta_r <= 1'b0;
      reg_s_r <= 1'b0;
    end else begin
      pdn_meta_r <= hw_power_down_pin_i;
      pdn_s_r <= pdn_meta_r;
      reg_meta_r <= regulator_output_pin_i;
      reg_s_r <= reg_meta_r;
    end
  end

  logic por_hold;
  assign por_hold = pdn_s_r || !reg_s_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_POR;
      por_cnt_r <= 8'h00;
      boot_addr_r <= '0;
    end else if (por_hold) begin
      state_r <= ST_POR;
      por_cnt_r <= 8'h00;
      boot_addr_r <= '0;
    end else begin
      case (state_r)
        ST_POR: begin
          if (por_cnt_r == 8'(POR_CYC - 1)) begin
            state_r <= ST_BOOT;
          end else begin
            por_cnt_r <= por_cnt_r + 8'h01;
          end
        end
        ST_BOOT: begin
          boot_addr_r <= boot_addr_r + 1'b1;
          if (boot_addr_r == RAM_LAST_IDX) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_POR;
      endcase
    end
  end

  // Access qualification
  logic run, lock_acq, allowed, ram_ok, wr_ok, rd_ok;
  logic [2:0] pll_idx;
  assign run = (state_r == ST_RUN);
  // Restricted window lasts until both enable and lock read as one
  assign lock_acq = pll_ctrl_r[PLL_EN_BIT] &&
                    !(locked_r && clk_ctrl_r[CC_CORE_EN]);
  assign ram_ok = dpd0_r[DPD0_MEMC_BIT] && dpd0_r[DPD0_DSP_BIT];
  assign allowed = is_clk_pll(cp_req_i.addr) || !lock_acq;
  assign wr_ok = run && cp_req_i.valid && cp_req_i.write && allowed;
  assign rd_ok = run && cp_req_i.valid && !cp_req_i.write && allowed;
  assign pll_idx = 3'(cp_req_i.addr - ADDR_PLL_FIRST);

  logic pll_hit;
  logic [47:0] shadow_nxt;
  logic [5:0] mask_nxt;
  always_comb begin
    pll_hit = wr_ok && (cp_req_i.addr >= ADDR_PLL_FIRST) &&
              (cp_req_i.addr <= ADDR_PLL_LAST);
    shadow_nxt = pll_shadow_r;
    mask_nxt = pll_mask_r;
    if (pll_hit) begin
      shadow_nxt[8*(PLL_BYTES-1-int'(pll_idx)) +: 8] = cp_req_i.wdata;
      mask_nxt[pll_idx] = 1'b1;
    end
  end

  logic pll_commit;
  // Partial bursts are dropped so the PLL never sees a torn setting
  assign pll_commit = cp_req_i.valid && cp_req_i.last && run &&
                      (mask_nxt == PLL_MASK_FULL);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_shadow_r <= PLL_RESET;
      pll_mask_r <= 6'h00;
      pll_ctrl_r <= PLL_RESET;
    end else if (!run) begin
      pll_shadow_r <= PLL_RESET;
      pll_mask_r <= 6'h00;
      pll_ctrl_r <= PLL_RESET;
    end else begin
      pll_shadow_r <= shadow_nxt;
      pll_mask_r <= (cp_req_i.valid && cp_req_i.last) ? 6'h00 : mask_nxt;
      if (pll_commit) begin
        pll_ctrl_r <= shadow_nxt;
        pll_ctrl_r[PLL_LOCK_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_ctrl_r <= CC_RESET;
      dpd0_r <= DPD_RESET;
      dpd1_r <= DPD_RESET;
    end else if (!run) begin
      clk_ctrl_r <= CC_RESET;
      dpd0_r <= DPD_RESET;
      dpd1_r <= DPD_RESET;
    end else if (wr_ok) begin
      if (cp_req_i.addr == ADDR_CLK_CTRL) begin
        clk_ctrl_r <= {4'h0, cp_req_i.wdata[3:0]};
      end else if (cp_req_i.addr == ADDR_DPD0) begin
        dpd0_r <= cp_req_i.wdata;
      end else if (cp_req_i.addr == ADDR_DPD1) begin
        dpd1_r <= cp_req_i.wdata;
      end
    end
  end

  // Lock timer restarts on every committed PLL setting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt_r <= 32'h0000_0000;
      locked_r <= 1'b0;
    end else if (!run || pll_commit || !pll_ctrl_r[PLL_EN_BIT]) begin
      lock_cnt_r <= 32'h0000_0000;
      locked_r <= 1'b0;
    end else if (!locked_r) begin
      lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
      if (lock_cnt_r == 32'(LOCK_CYCLES - 1)) begin
        locked_r <= 1'b1;
      end
    end
  end

  // Internal memory: boot clears it, host reaches it once enabled
  logic ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata;
  always_comb begin
    ram_we = 1'b0;
    ram_addr = cp_req_i.addr[RAM_AW-1:0];
    ram_wdata = cp_req_i.wdata;
    if (state_r == ST_BOOT) begin
      ram_we = 1'b1;
      ram_addr = boot_addr_r;
      ram_wdata = 8'h00;
    end else if (wr_ok && ram_ok && is_ram(cp_req_i.addr)) begin
      ram_we = 1'b1;
    end
  end

  csg_ram u_ram (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // Reads answer two edges after the request so RAM data can settle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_r <= 1'b0;
      rd_ram_r <= 1'b0;
      rd_addr_r <= 16'h0000;
    end else begin
      rd_pend_r <= rd_ok;
      rd_ram_r <= ram_ok && is_ram(cp_req_i.addr);
      rd_addr_r <= cp_req_i.addr;
    end
  end

  logic [7:0] rd_mux;
  logic [2:0] rd_idx;
  logic [47:0] pll_view;
  always_comb begin
    rd_idx = 3'(rd_addr_r - ADDR_PLL_FIRST);
    pll_view = pll_ctrl_r;
    pll_view[PLL_LOCK_BIT] = locked_r;
    rd_mux = 8'h00;
    if (rd_addr_r == ADDR_CLK_CTRL) begin
      rd_mux = clk_ctrl_r;
    end else if (rd_addr_r >= ADDR_PLL_FIRST &&
                 rd_addr_r <= ADDR_PLL_LAST) begin
      rd_mux = pll_view[8*(PLL_BYTES-1-int'(rd_idx)) +: 8];
    end else if (rd_addr_r == ADDR_DPD0) begin
      rd_mux = dpd0_r;
    end else if (rd_addr_r == ADDR_DPD1) begin
      rd_mux = dpd1_r;
    end else if (rd_ram_r && is_ram(rd_addr_r)) begin
      rd_mux = ram_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_rdata_o <= 8'h00;
      cp_rvalid_o <= 1'b0;
    end else begin
      cp_rvalid_o <= rd_pend_r;
      cp_rdata_o <= rd_pend_r ? rd_mux : 8'h00;
    end
  end

  // Outputs toward clocks, power and filters
  logic clk_ok;
  assign clk_ok = run && clk_ctrl_r[CC_CORE_EN] &&
                  (!clk_ctrl_r[CC_SRC] || locked_r);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_done_o <= 1'b0;
      regulator_en_o <= 1'b0;
      core_clk_gate_o <= 1'b0;
      core_clk_src_o <= 1'b0;
      core_clk_div_o <= 2'b00;
      pll_power_o <= 1'b0;
      subsys_en_o <= 16'h0000;
      adc_osr_128_o <= 1'b1;
      dac_osr_128_o <= 1'b1;
    end else begin
      boot_done_o <= run;
      regulator_en_o <= !pdn_s_r;
      core_clk_gate_o <= clk_ok;
      core_clk_src_o <= clk_ctrl_r[CC_SRC];
      core_clk_div_o <= clk_ctrl_r[CC_DIV_LSB +: 2];
      pll_power_o <= run && pll_ctrl_r[PLL_EN_BIT];
      subsys_en_o <= run ? {dpd1_r, dpd0_r} : 16'h0000;
      adc_osr_128_o <= !adc_osr_low_i;
      dac_osr_128_o <= !dac_osr_low_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_por_defaults: assert property (
    !run |=> (clk_ctrl_r == CC_RESET) && (dpd0_r == DPD_RESET))
    else $error("registers not at default outside run");
  a_boot_ignore: assert property (
    (!run && cp_req_i.valid) |->
    ##2 !cp_rvalid_o)
    else $error("host request answered before boot");
  a_div_follow: assert property (
    (run && wr_ok && cp_req_i.addr == ADDR_CLK_CTRL) |=> ##1
    core_clk_div_o == $past(cp_req_i.wdata[2:1], 2))
    else $error("divider output does not follow clock control");
  a_gate_enable: assert property (
    !clk_ctrl_r[CC_CORE_EN] |=> !core_clk_gate_o)
    else $error("core clock running without enable");
  a_gate_lock: assert property (
    (clk_ctrl_r[CC_SRC] && !locked_r) |=> !core_clk_gate_o)
    else $error("core clock running during lock acquisition");
  a_lock_window: assert property (
    (lock_acq && cp_req_i.valid && cp_req_i.write &&
     cp_req_i.addr == ADDR_DPD0 && run) |=> $stable(dpd0_r))
    else $error("restricted register written during lock");
  a_lock_time: assert property (
    $rose(locked_r) |-> $past(lock_cnt_r) == 32'(LOCK_CYCLES - 1))
    else $error("lock reported at wrong time");
  a_subsys_off: assert property (
    !dpd0_r[DPD0_ADC_BIT] |=> !subsys_en_o[DPD0_ADC_BIT])
    else $error("ADC powered without enable");
  a_pdn_reset: assert property (
    pdn_s_r |=> !regulator_en_o && state_r == ST_POR ##1 !boot_done_o)
    else $error("power-down pin did not stop device");
  a_pll_burst: assert property (
    (cp_req_i.valid && cp_req_i.last && mask_nxt != PLL_MASK_FULL)
    |=> $stable(pll_ctrl_r))
    else $error("partial PLL burst was committed");

  c_boot_done: cover property ($rose(run));
  c_pll_lock: cover property ($rose(locked_r));
  c_core_clk_pll: cover property ($rose(core_clk_gate_o) && core_clk_src_o);
  c_pdn_cycle: cover property ($fell(pdn_s_r) ##[1:100] run);
endmodule // csg_top
`default_nettype wire

// *** csg_host_model.sv ***
// Purpose: Host model issuing decoded control-port bytes
// Assumes: Bytes launched on the falling clock edge
// Notes: Idle bus shows inverted fields so stale values never match
`timescale 1ns/100ps
`default_nettype none
module csg_host_model
  import csg_pkg::*;
(
  input wire logic clk_i,
  output csg_pkg::csg_cp_req_t req_o
);
  initial req_o = '0;
  // Back-to-back calls form one burst; the PLL word goes out one byte per call
  task automatic put(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic l);
    @(negedge clk_i);
    req_o <= '{valid: 1'b1, write: w, last: l, addr: a, wdata: d};
  endtask
  // Gap lets the host be prompt or slow between transactions
  task automatic idle(input int gap);
    @(negedge clk_i);
    req_o <= '{1'b0, 1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
    repeat (gap) @(negedge clk_i);
  endtask
endmodule // csg_host_model
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for boot, access gating and clock gating
// Assumes: Lock timer shortened to LKC cycles
// Notes: Expected read data queue up and are matched on each read pulse
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; \
  if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  import csg_pkg::*;
  localparam int LKC = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hw_power_down_pin = 1'b0;
  logic reg_ok = 1'b1;
  logic adc_lo = 1'b0;
  logic dac_lo = 1'b0;
  csg_cp_req_t req;
  logic [7:0] rd_o, e_r, d, e;
  logic rv, bd, ren, gate, src, pllp, a128, d128, lk;
  logic [1:0] div;
  logic [15:0] sub;
  logic [7:0] regs [int];
  logic [7:0] expq [$];
  int n_errors = 0;
  int check_count = 0;

  csg_host_model i_host (.clk_i(clk_i), .req_o(req));
  csg_top #(.LOCK_CYCLES(LKC)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hw_power_down_pin_i(hw_power_down_pin),
    .regulator_output_pin_i(reg_ok), .adc_osr_low_i(adc_lo),
    .dac_osr_low_i(dac_lo), .cp_req_i(req), .cp_rdata_o(rd_o),
    .cp_rvalid_o(rv), .boot_done_o(bd), .regulator_en_o(ren),
    .core_clk_gate_o(gate), .core_clk_src_o(src),
    .core_clk_div_o(div), .pll_power_o(pllp), .subsys_en_o(sub),
    .adc_osr_128_o(a128), .dac_osr_128_o(d128));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] g(int a);
    return regs.exists(a) ? regs[a] : 8'h00;
  endfunction

  // RAM reads zero until memory controller and core are powered
  function automatic logic [7:0] exp_rd(int a);
    logic [7:0] v;
    v = g(a);
    if (a == 32'h4007) v[1] = lk;
    if (a < RAM_DEPTH && (g(32'h4080) & 8'h41) != 8'h41) v = 8'h00;
    return v;
  endfunction

  task automatic step(int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic acc(logic w, int a, logic [7:0] dv, logic l, logic ok);
    i_host.put(w, a[15:0], dv, l);
    if (ok && w) regs[a] = (a == 32'h4000) ? (dv & 8'h0F) : dv;
    if (ok && !w) expq.push_back(exp_rd(a));
    if (l) i_host.idle($urandom_range(3));
  endtask

  task automatic wait_boot();
    int i;
    i = 0;
    while (bd !== 1'b1 && i < 300) begin
      @(negedge clk_i);
      i++;
    end
    `CHK("boot_done", 1'b1, bd)
  endtask

  task automatic tdone(string s);
    $display("test %s done", s);
  endtask

  // Read pulse is looked at mid-cycle, away from the edge that launches it
  always @(negedge clk_i) begin
    if (rv === 1'b1) begin
      if (expq.size() == 0) `CHK("rvalid", 1'b0, rv)
      else begin
        e_r = expq.pop_front();
        `CHK("rdata", e_r, rd_o)
      end
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 5000);
    n_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(29618));
    lk = 1'b0;
    step(20);
    `CHK("rst_osr", 1'b1, a128)
    `CHK("rst_sub", 16'h0000, sub)
    rst_n_i = 1'b1;
    acc(1, 32'h4000, 8'h01, 1, 0);
    wait_boot();
    acc(0, 32'h4000, 8'h00, 1, 1);
    `CHK("early_gate", 1'b0, gate)
    adc_lo = 1'($urandom);
    dac_lo = ~adc_lo;
    step(3);
    `CHK("adc_osr", ~adc_lo, a128)
    `CHK("dac_osr", ~dac_lo, d128)
    tdone("boot");
    for (int k = 0; k < 4; k++) begin
      acc(1, 32'h4000, 8'(k << 1) | 8'h01, 1, 1);
      step(3);
      `CHK("clk_div", k[1:0], div)
      `CHK("clk_gate", 1'b1, gate)
      `CHK("clk_src", 1'b0, src)
    end
    acc(1, 32'h4000, 8'h06, 1, 1);
    step(3);
    `CHK("clk_off", 1'b0, gate)
    acc(0, 32'h4000, 8'h00, 1, 1);
    tdone("direct_clock");
    acc(1, 32'h0005, 8'hA5, 1, 0);
    acc(0, 32'h0005, 8'h00, 1, 1);
    d = 8'($urandom) | 8'h41;
    e = 8'($urandom);
    acc(1, 32'h4080, d, 1, 1);
    acc(1, 32'h4081, e, 1, 1);
    step(3);
    `CHK("subsys", {e, d}, sub)
    acc(1, 32'h0005, e, 1, 1);
    acc(0, 32'h0005, 8'h00, 1, 1);
    acc(0, 32'h5000, 8'h00, 1, 1);
    tdone("power_regs");
    acc(1, 32'h4000, 8'h08, 1, 1);
    for (int k = 2; k < 8; k++)
      acc(1, 32'h4000 + k, k == 7 ? 8'h01 : 8'($urandom), k == 7, 1);
    acc(0, 32'h4007, 8'h00, 1, 1);
    acc(0, 32'h4080, 8'h00, 1, 0);
    acc(1, 32'h4080, 8'hFF, 1, 0);
    `CHK("pll_on", 1'b1, pllp)
    `CHK("lock_gate", 1'b0, gate)
    // Host waits out the lock time before enabling the core clock
    step(LKC + 5);
    lk = 1'b1;
    acc(0, 32'h4007, 8'h00, 1, 1);
    `CHK("no_en_gate", 1'b0, gate)
    acc(1, 32'h4000, 8'h09, 1, 1);
    step(3);
    `CHK("pll_gate", 1'b1, gate)
    `CHK("pll_src", 1'b1, src)
    acc(0, 32'h4080, 8'h00, 1, 1);
    acc(1, 32'h4002, 8'h5A, 0, 0);
    acc(1, 32'h4003, 8'h5A, 1, 0);
    acc(0, 32'h4002, 8'h00, 1, 1);
    tdone("pll");
    // No output was ever unmuted here, so nothing to mute first
    hw_power_down_pin = 1'b1;
    step(5);
    `CHK("regulator", 1'b0, ren)
    `CHK("pdn_boot", 1'b0, bd)
    `CHK("pdn_sub", 16'h0000, sub)
    `CHK("pdn_pll", 1'b0, pllp)
    hw_power_down_pin = 1'b0;
    regs.delete();
    lk = 1'b0;
    wait_boot();
    acc(0, 32'h4000, 8'h00, 1, 1);
    acc(0, 32'h4007, 8'h00, 1, 1);
    acc(0, 32'h4080, 8'h00, 1, 1);
    // Memory written before power-down must read back cleared by boot
    acc(1, 32'h4080, 8'h41, 1, 1);
    acc(0, 32'h0005, 8'h00, 1, 1);
    tdone("power_pin");
    acc(1, 32'h4000, 8'h01, 1, 1);
    reg_ok = 1'b0;
    step(5);
    `CHK("reg_low_boot", 1'b0, bd)
    reg_ok = 1'b1;
    regs.delete();
    wait_boot();
    acc(0, 32'h4000, 8'h00, 1, 1);
    acc(0, 32'h4080, 8'h00, 1, 1);
    tdone("regulator");
    step(6);
    `CHK("pending", 0, expq.size())
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
